//--- hw/touch_cdc_power_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "touch_cdc_map.svh"
module touch_cdc_power_mode_control
    import touch_cdc_pkg::*;
#(
    parameter int STAGES = 8,
    parameter int FAST_CYC = `FAST_MS * `CLK_KHZ,
    parameter int IDLE_UNIT_CYC = `IDLE_UNIT_MS * `CLK_KHZ
) (
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic scl_i, // Serial clock in
    input wire logic sda_i, // Serial data in
    output logic sda_o, // Serial data out, always low
    output logic sda_oe, // High while pulling data low
    output logic int_o, // Interrupt out, always low
    output logic int_oe, // High while pulling interrupt low
    input wire logic res_valid, // Converter result ready
    input wire logic [15:0] res_data, // Converter result
    output logic conv_start, // Start one stage conversion
    output logic [2:0] conv_stage, // Stage being converted
    output logic [15:0] conv_route, // Two bits per sensor pin
    output logic analog_on, // Converter at full power
    output logic comp_update // Baseline refreshed pulse
);
    seq_t st_q;
    i2c_t ist_q;
    logic [15:0] ctrl_q, amb_q, intcfg_q, rd_data, wr_data_q, txw;
    logic [15:0] route_r [STAGES];
    logic [15:0] thr_r [STAGES];
    logic [15:0] result_r [STAGES];
    logic [15:0] base_ram [`RAM_WORDS];
    logic [STAGES-1:0] cal_ok_q, touch_q, touch_acc_q;
    logic [1:0] act_mode_q;
    logic [2:0] stage_q;
    logic [31:0] timer_q, tgt;
    logic [3:0] rel_q, cnt_q;
    logic [7:0] sh_q, ptr_q;
    logic scl_q, sda_q, hi_q, wr_q, rd_clr, pend_q, fast_sel;
    logic seq_end, new_act, touched, pos_in, last;
    logic signed [16:0] dr, dl;
    logic [15:0] base_cur;
    wire logic scl_rise = scl_i & ~scl_q;
    wire logic scl_fall = ~scl_i & scl_q;
    wire logic i_start = scl_i & scl_q & sda_q & ~sda_i;
    wire logic i_stop = scl_i & scl_q & ~sda_q & sda_i;

    // Address falls inside an eight-word block
    function automatic logic in_blk(input logic [7:0] p, input logic [7:0] b);
        in_blk = (p[7:3] == b[7:3]);
    endfunction : in_blk

    // Any pin of the stage on the positive input
    function automatic logic any_pos(input logic [15:0] r);
        any_pos = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (r[2*i +: 2] == RT_POS) any_pos = 1'b1;
        end
    endfunction : any_pos

    // Serial sampling; pins are synchronous so one flop serves edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Serial slave: address, pointer, then 16-bit words high byte first
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ist_q <= I_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            hi_q <= 1'b1;
            sda_oe <= 1'b0;
            wr_q <= 1'b0;
            rd_clr <= 1'b0;
            wr_data_q <= 16'h0000;
        end else begin
            wr_q <= 1'b0;
            rd_clr <= 1'b0;
            if (i_start) begin
                ist_q <= I_ADDR;
                cnt_q <= 4'h0;
                sda_oe <= 1'b0;
            end else if (i_stop) begin
                ist_q <= I_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise && ist_q != I_IDLE) begin
                if (cnt_q != 4'h8) begin
                    sh_q <= {sh_q[6:0], sda_i};
                    cnt_q <= cnt_q + 4'h1;
                end else begin
                    cnt_q <= 4'h0;
                    if (ist_q == I_RD && sda_i) ist_q <= I_IDLE; // Host refused more
                end
            end else if (scl_fall && ist_q != I_IDLE) begin
                if (cnt_q == 4'h8) begin
                    sda_oe <= 1'b1;
                    unique case (ist_q)
                        I_ADDR: begin
                            hi_q <= 1'b1;
                            if (sh_q[7:1] == `DEV_ADDR) ist_q <= sh_q[0] ? I_RD : I_PTR;
                            else begin
                                ist_q <= I_IDLE;
                                sda_oe <= 1'b0;
                            end
                        end
                        I_PTR: begin
                            ptr_q <= sh_q;
                            ist_q <= I_WR;
                        end
                        I_WR: begin
                            hi_q <= ~hi_q;
                            if (hi_q) wr_data_q[15:8] <= sh_q;
                            else begin
                                wr_data_q[7:0] <= sh_q;
                                wr_q <= 1'b1;
                            end
                        end
                        I_RD: begin
                            sda_oe <= 1'b0; // Host acknowledges
                            hi_q <= ~hi_q;
                            if (!hi_q) begin
                                ptr_q <= ptr_q + 8'h01;
                                rd_clr <= (ptr_q == `A_STATUS);
                            end
                        end
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (ist_q == I_RD) begin
                    sda_oe <= ~txw[{hi_q, 3'(4'd7 - cnt_q)}]; // High byte takes bits 15:8
                end else begin
                    sda_oe <= 1'b0;
                end
            end
            if (wr_q) ptr_q <= ptr_q + 8'h01; // Auto-increment after a word
        end
    end

    // Register read mux
    always_comb begin
        rd_data = 16'h0000;
        if (ptr_q == `A_CTRL) rd_data = ctrl_q;
        else if (ptr_q == `A_AMB) rd_data = amb_q;
        else if (ptr_q == `A_INTCFG) rd_data = intcfg_q;
        else if (ptr_q == `A_STATUS) rd_data = {pend_q, 7'h00, touch_q};
        else if (in_blk(ptr_q, `A_ROUTE)) rd_data = route_r[ptr_q[2:0]];
        else if (in_blk(ptr_q, `A_THR)) rd_data = thr_r[ptr_q[2:0]];
        else if (in_blk(ptr_q, `A_RESULT)) rd_data = result_r[ptr_q[2:0]];
        txw = rd_data;
    end

    // Global control words; mode and interval share one word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= `RST_CTRL;
            amb_q <= `RST_AMB;
            intcfg_q <= 16'h0000;
        end else if (wr_q) begin
            if (ptr_q == `A_CTRL) ctrl_q <= wr_data_q;
            if (ptr_q == `A_AMB) amb_q <= wr_data_q;
            if (ptr_q == `A_INTCFG) intcfg_q <= {15'h0000, wr_data_q[`F_INT_POL]};
        end
    end

    // Per-stage routing and threshold, tuned independently
    for (genvar s = 0; s < STAGES; s++) begin : g_stage
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                route_r[s] <= `RST_ROUTE;
                thr_r[s] <= `RST_THR;
            end else if (wr_q && ptr_q == (`A_ROUTE + 8'(s))) begin
                route_r[s] <= wr_data_q;
            end else if (wr_q && ptr_q == (`A_THR + 8'(s))) begin
                thr_r[s] <= wr_data_q;
            end
        end
    end

    // Activation test against the stored baseline
    always_comb begin
        base_cur = base_ram[stage_q];
        pos_in = any_pos(route_r[stage_q]);
        dr = $signed({1'b0, res_data}) - $signed({1'b0, base_cur});
        dl = pos_in ? -dr : dr;
        touched = cal_ok_q[stage_q] && (dl > $signed({1'b0, thr_r[stage_q]}));
        last = (stage_q == 3'(STAGES - 1));
        seq_end = (st_q == S_WAIT) && res_valid && last;
        new_act = (st_q == S_WAIT) && res_valid && touched && !touch_q[stage_q];
        fast_sel = (|touch_acc_q) || (rel_q != 4'h0);
        tgt = fast_sel ? 32'(FAST_CYC) : 32'(32'(ctrl_q[`F_IDLE]) + 32'd1) * 32'(IDLE_UNIT_CYC);
    end

    // Sequencer; mode is resampled only between sequences
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= S_OFF;
            act_mode_q <= MODE_FULL;
            stage_q <= 3'h0;
            timer_q <= 32'h0000_0000;
            conv_start <= 1'b0;
            conv_route <= 16'h0000;
        end else begin
            conv_start <= 1'b0;
            timer_q <= (st_q == S_OFF) ? 32'h0000_0000 : timer_q + 32'h0000_0001;
            unique case (st_q)
                S_OFF: begin
                    act_mode_q <= ctrl_q[`F_MODE];
                    if (ctrl_q[0] == 1'b0) st_q <= S_CONV;
                    timer_q <= 32'h0000_0000;
                end
                S_CONV: begin
                    conv_start <= 1'b1;
                    conv_route <= route_r[stage_q];
                    st_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (res_valid) begin
                        stage_q <= last ? 3'h0 : stage_q + 3'h1;
                        st_q <= S_CONV;
                        if (last) begin
                            act_mode_q <= ctrl_q[`F_MODE];
                            if (ctrl_q[0]) st_q <= S_OFF;
                            else if (ctrl_q[`F_MODE] == MODE_FULL) timer_q <= 32'h0000_0000;
                            else st_q <= S_PAUSE;
                        end
                    end
                end
                S_PAUSE: begin
                    if (timer_q >= tgt - 32'h0000_0001) begin
                        act_mode_q <= ctrl_q[`F_MODE];
                        timer_q <= 32'h0000_0000;
                        st_q <= ctrl_q[0] ? S_OFF : S_CONV;
                    end
                end
            endcase
        end
    end

    // Results, touch state and release timeout
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            touch_q <= '0;
            touch_acc_q <= '0;
            rel_q <= 4'h0;
            cal_ok_q <= '0;
            comp_update <= 1'b0;
            for (int i = 0; i < STAGES; i++) result_r[i] <= 16'h0000;
        end else begin
            comp_update <= 1'b0;
            if (st_q == S_WAIT && res_valid) begin
                result_r[stage_q] <= res_data;
                touch_q[stage_q] <= touched;
                touch_acc_q[stage_q] <= touched;
                cal_ok_q[stage_q] <= 1'b1;
                comp_update <= !touched;
            end
            if (seq_end) begin
                if ((touch_acc_q | STAGES'(touched) << stage_q) != '0) rel_q <= amb_q[`F_TIMEOUT];
                else if (rel_q != 4'h0) rel_q <= rel_q - 4'h1;
            end
        end
    end

    // Baseline RAM, tracks the ambient level while untouched
    always_ff @(posedge clk_sys) begin
        if (st_q == S_WAIT && res_valid && !touched) begin
            base_ram[stage_q] <= cal_ok_q[stage_q] ? base_cur + 16'(dr >>> 4) : res_data;
        end
    end

    // Interrupt pending; a new event beats a status read
    always_ff @(posedge clk_sys) begin
        if (rst) pend_q <= 1'b0;
        else if (seq_end || new_act) pend_q <= 1'b1;
        else if (rd_clr) pend_q <= 1'b0;
    end

    // Open-drain pins; the drive enable carries the logic level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_oe <= 1'b0;
            int_o <= 1'b0;
            sda_o <= 1'b0;
            conv_stage <= 3'h0;
            analog_on <= 1'b0;
        end else begin
            int_oe <= pend_q ^ intcfg_q[`F_INT_POL];
            int_o <= 1'b0;
            sda_o <= 1'b0;
            conv_stage <= stage_q;
            analog_on <= (st_q == S_CONV) || (st_q == S_WAIT) || (st_q == S_PAUSE && fast_sel);
        end
    end

    sequence seq_done_s;
        seq_end ##0 !ctrl_q[0];
    endsequence

    chk_reset_mode: assert property (@(posedge clk_sys) rst |=> ctrl_q[1:0] == 2'b00)
        else $error("mode not full power after reset");
    chk_off_noconv: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == S_OFF |=> !conv_start && !comp_update)
        else $error("activity while shut down");
    chk_full_b2b: assert property (@(posedge clk_sys) disable iff (rst)
        seq_done_s ##0 ctrl_q[1] == 1'b0 |=> st_q == S_CONV ##1 conv_start)
        else $error("full power sequence not back to back");
    chk_low_pause: assert property (@(posedge clk_sys) disable iff (rst)
        seq_done_s ##0 ctrl_q[1:0] == 2'b10 |=> st_q == S_PAUSE)
        else $error("low power did not pause");
    chk_fast_rate: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == S_PAUSE && fast_sel |-> timer_q < 32'(FAST_CYC))
        else $error("touched interval too long");
    chk_idle_rate: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == S_PAUSE |-> timer_q < 32'(4 * IDLE_UNIT_CYC))
        else $error("idle interval too long");
    chk_act_irq: assert property (@(posedge clk_sys) disable iff (rst)
        new_act |=> pend_q ##1 int_oe == !intcfg_q[0])
        else $error("activation did not raise interrupt");
    chk_int_pol: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 int_oe == ($past(pend_q) ^ $past(intcfg_q[0])))
        else $error("interrupt polarity wrong");
    chk_route_out: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == S_CONV |=> conv_start && conv_route == $past(route_r[stage_q]))
        else $error("routing not applied");
    chk_mode_hold: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == S_WAIT && !res_valid |=> $stable(act_mode_q))
        else $error("mode changed inside sequence");
    chk_release: assert property (@(posedge clk_sys) disable iff (rst)
        seq_end && touched |=> rel_q == $past(amb_q[3:0]))
        else $error("release timeout not loaded");
endmodule : touch_cdc_power_mode_control
`default_nettype wire

//--- hw/touch_cdc_map.svh
// How it works
// - Mode 00 full, 10 low power, else shutdown
// - Mode field resets to full power
// - Mode field is bits 1:0 at 0x000
// - Full power runs sequences back to back
// - Untouched conversions refresh the ambient baseline
// - Low power idle waits 200 to 800 ms
// - Touched low power converts every 25 ms
// - Release timeout holds full power after touch
// - Shutdown performs no conversions or updates
// - Threshold crossing registers touch, updates status
// - Interrupt flags new data and activation
// - Results stored in registers, host reads them
// - Each conversion is a 16-bit value
// - Per-stage two-bit routing for eight pins
// - Positive input falls, negative rises on touch
// - Each stage has its own settings
// - Button state is decided on chip
// - 528-word RAM holds calibration, runs continuously
// - Idle interval is bits 3:2 at 0x000
// - Interrupt pin open drain, polarity selectable
`ifndef TOUCH_CDC_MAP_SVH
`define TOUCH_CDC_MAP_SVH
`define A_CTRL 8'h00
`define A_AMB 8'h02
`define A_INTCFG 8'h04
`define A_STATUS 8'h08
`define A_ROUTE 8'h10
`define A_THR 8'h18
`define A_RESULT 8'h20
`define F_MODE 1:0
`define F_IDLE 3:2
`define F_TIMEOUT 3:0
`define F_INT_POL 0
`define RST_CTRL 16'h0000
`define RST_AMB 16'h0004
`define RST_ROUTE 16'h0000
`define RST_THR 16'h0100
`define FAST_MS 25
`define IDLE_UNIT_MS 200
`define CLK_KHZ 25000
`define RAM_WORDS 528
`define DEV_ADDR 7'h2C
`endif

//--- hw/touch_cdc_pkg.sv
`default_nettype none
package touch_cdc_pkg;
    typedef enum logic [1:0] {
        MODE_FULL = 2'b00, MODE_OFF_A = 2'b01, MODE_LOW = 2'b10, MODE_OFF_B = 2'b11
    } mode_t;
    typedef enum logic [1:0] {
        RT_FLOAT = 2'b00, RT_NEG = 2'b01, RT_POS = 2'b10, RT_SHIELD = 2'b11
    } route_t;
    typedef enum logic [1:0] {
        S_OFF = 2'b00, S_CONV = 2'b01, S_WAIT = 2'b10, S_PAUSE = 2'b11
    } seq_t;
    typedef enum logic [2:0] {
        I_IDLE = 3'b000, I_ADDR = 3'b001, I_PTR = 3'b010, I_WR = 3'b011, I_RD = 3'b100
    } i2c_t;
endpackage : touch_cdc_pkg
`default_nettype wire

//--- test/i2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "touch_cdc_map.svh"
// Bus host; open drain, so a 1 on sda_h only lets the pull-up win
module i2c_host_model #(
    parameter int HALF = 4
) (
    input wire logic clk_sys, // System clock
    input wire logic sda_w, // Resolved data wire
    output logic scl, // Serial clock, idle high
    output logic sda_h // Data drive, 1 releases
);
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end

    // Phases in system clocks; the device samples scl with no synchroniser
    task automatic half();
        repeat (HALF) @(posedge clk_sys);
    endtask : half

    // Also serves as repeated start from a low clock
    task automatic start();
        sda_h <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_h <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask : start

    task automatic stop();
        sda_h <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_h <= 1'b1;
        half();
    endtask : stop

    // Data changes only a half after the fall, so it never races the clock
    task automatic bit_io(input logic b, output logic v);
        sda_h <= b;
        half();
        scl <= 1'b1;
        half();
        v = sda_w;
        scl <= 1'b0;
        half();
    endtask : bit_io

    task automatic byte_io(input logic [7:0] b, output logic [7:0] v);
        logic t;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], t);
            v[i] = t;
        end
    endtask : byte_io

    // Byte out, device acknowledge returned in a (0 = acked)
    task automatic send(input logic [7:0] b, output logic a);
        logic [7:0] junk;
        byte_io(b, junk);
        bit_io(1'b1, a);
    endtask : send

    // Word write, high byte first; n counts missing acknowledges
    task automatic write_reg(input logic [7:0] p, input logic [15:0] d, output int n);
        logic a;
        n = 0;
        start();
        for (int i = 0; i < 4; i++) begin
            send(i == 0 ? {`DEV_ADDR, 1'b0} : i == 1 ? p : i == 2 ? d[15:8] : d[7:0], a);
            n += int'(a);
        end
        stop();
    endtask : write_reg

    // Pointer set, then repeated start and a word read back
    task automatic read_reg(input logic [7:0] p, output logic [15:0] d);
        logic a;
        logic [7:0] h, l;
        start();
        send({`DEV_ADDR, 1'b0}, a);
        send(p, a);
        start();
        send({`DEV_ADDR, 1'b1}, a);
        byte_io(8'hFF, h);
        bit_io(1'b0, a);
        byte_io(8'hFF, l);
        bit_io(1'b1, a);
        stop();
        d = {h, l};
    endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

//--- test/touch_cdc_power_mode_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module touch_cdc_power_mode_control_tb_top
    import touch_cdc_pkg::*;
;
    localparam int FAST = 300;
    localparam int IDLE = 1000;
    localparam int DLY = 3;
    localparam logic [15:0] BASE = 16'h8000;
    logic clk_sys;
    logic rst = 1'b1;
    logic touch = 1'b0;
    logic res_valid = 1'b0;
    logic [15:0] res_data = 16'h0000;
    logic scl, sda_h, sda_w, int_w, sda_o, sda_oe, int_o, int_oe;
    logic conv_start, analog_on, comp_update, ao_mid;
    logic [2:0] conv_stage;
    logic [15:0] conv_route, rd;
    int cnt = 0;
    int err_total = 0;
    int num_checks = 0;
    int g, nc, n;

    // Pull-ups on both open-drain wires
    assign sda_w = sda_oe ? sda_o : sda_h;
    assign int_w = int_oe ? int_o : 1'b1;

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    i2c_host_model i2c_host_model_inst (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl),
        .sda_h(sda_h));
    touch_cdc_power_mode_control #(.FAST_CYC(FAST), .IDLE_UNIT_CYC(IDLE))
        touch_cdc_power_mode_control_inst (.clk_sys(clk_sys), .rst(rst), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
        .res_valid(res_valid), .res_data(res_data), .conv_start(conv_start),
        .conv_stage(conv_stage), .conv_route(conv_route), .analog_on(analog_on),
        .comp_update(comp_update));

    // Converter stand-in: touch pulls stage 0 down and stage 1 up
    always @(posedge clk_sys) begin
        res_valid <= (cnt == 1);
        if (cnt == 1) begin
            res_data <= BASE - ((touch && conv_stage == 3'h0) ? 16'h0400 : 16'h0000)
                + ((touch && conv_stage == 3'h1) ? 16'h0400 : 16'h0000);
        end
        if (conv_start) begin
            cnt <= DLY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
        i2c_host_model_inst.read_reg(p, rd);
        check(rd, exp);
    endtask : rd_chk

    // Bounded, so a dead sequencer cannot hang the run
    task automatic wait_stage(input logic [2:0] s);
        int k;
        k = 0;
        @(posedge clk_sys);
        while (!(conv_start === 1'b1 && conv_stage === s) && k < 6000) begin
            @(posedge clk_sys);
            k++;
        end
    endtask : wait_stage

    // Cycles and baseline pulses between two sequence starts
    task automatic seq_gap();
        wait_stage(3'h0);
        g = 0;
        nc = 0;
        do begin
            @(posedge clk_sys);
            g++;
            nc += int'(comp_update);
            if (g == 500) begin
                ao_mid = analog_on;
            end
        end while (!(conv_start === 1'b1 && conv_stage === 3'h0) && g < 6000);
    endtask : seq_gap

    function automatic logic [15:0] near(input int a, input int e);
        return {15'h0000, (a >= e - 20) && (a <= e + 20)};
    endfunction : near

    task automatic t_regs();
        rd_chk(8'h00, 16'h0000);
        rd_chk(8'h02, 16'h0004);
        rd_chk(8'h30, 16'h0000);
        i2c_host_model_inst.write_reg(8'h00, 16'h000C, n);
        check(16'(n), 16'h0000);
        rd_chk(8'h00, 16'h000C);
        i2c_host_model_inst.write_reg(8'h00, 16'h0000, n);
    endtask : t_regs

    task automatic t_full();
        seq_gap();
        check(16'(g), 16'(8 * (DLY + 3)));
        check({15'h0000, analog_on}, 16'h0001);
        check(16'(nc), 16'h0008);
        rd_chk(8'h20, BASE);
    endtask : t_full

    // Unused pins go to shield; one positive and one negative stage
    task automatic t_route();
        i2c_host_model_inst.write_reg(8'h10, 16'hFFFE, n);
        i2c_host_model_inst.write_reg(8'h11, 16'hFFF7, n);
        wait_stage(3'h0);
        check(conv_route, 16'hFFFE);
        wait_stage(3'h1);
        check(conv_route, 16'hFFF7);
    endtask : t_route

    task automatic t_touch();
        touch <= 1'b1;
        seq_gap();
        check(16'(nc), 16'h0006);
        check({15'h0000, int_w}, 16'h0000);
        i2c_host_model_inst.write_reg(8'h04, 16'h0001, n);
        wait_stage(3'h0);
        check({15'h0000, int_oe}, 16'h0000);
        i2c_host_model_inst.write_reg(8'h04, 16'h0000, n);
        rd_chk(8'h08, 16'h8003);
        touch <= 1'b0;
    endtask : t_touch

    task automatic t_off();
        mode_t offs [2] = '{MODE_OFF_A, MODE_OFF_B};
        for (int c = 0; c < 2; c++) begin
            i2c_host_model_inst.write_reg(8'h00, {14'h0000, offs[c]}, n);
            repeat (300) @(posedge clk_sys);
            i2c_host_model_inst.read_reg(8'h08, rd);
            nc = 0;
            repeat (2000) begin
                @(posedge clk_sys);
                nc += int'(conv_start) + int'(comp_update);
            end
            check(16'(nc), 16'h0000);
            check({14'h0000, analog_on, int_w}, 16'h0001);
        end
    endtask : t_off

    task automatic t_low();
        // Release count 3: two untouched gaps stay fast before idling
        i2c_host_model_inst.write_reg(8'h02, 16'h0003, n);
        for (int i = 0; i < 4; i++) begin
            i2c_host_model_inst.write_reg(8'h00, {12'h000, 2'(i), MODE_LOW}, n);
            seq_gap();
            seq_gap();
            check(near(g, (i + 1) * IDLE), 16'h0001);
            check({15'h0000, ao_mid}, 16'h0000);
        end
        i2c_host_model_inst.write_reg(8'h00, {12'h000, 2'b00, MODE_LOW}, n);
        seq_gap();
        touch <= 1'b1;
        seq_gap();
        check(near(g, FAST), 16'h0001);
        touch <= 1'b0;
        seq_gap();
        check(near(g, FAST), 16'h0001);
        repeat (3) seq_gap();
        check(near(g, IDLE), 16'h0001);
    endtask : t_low

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_regs();
        t_full();
        t_route();
        t_touch();
        t_off();
        t_low();
        complete_run();
    end

    // Watchdog well beyond the expected run of about 60000 cycles
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end
endmodule : touch_cdc_power_mode_control_tb_top
`default_nettype wire
